// File: design/wdrt_top.v
// Watchdog reset timer: two-bit counter on a 1 Hz tick, APB register slave.
// Assumes one pclk domain; sleep and halt levels arrive on the same clock.
//
// What this block does
// [R01] Two-bit counter stepped by 1 Hz; upper stage overflow requests reset.
// [R02] Without restart for three to four seconds, reset goes to the CPU.
// [R03] Counting continues during HALT; timeout includes HALT time.
// [R04] Counter holds while oscillation stops in SLEEP, then resumes from there.
// [R05] Half and quarter hertz stages are readable; writes to them are ignored.
// [R06] Initial reset clears both counter stages.
// [R07] Writing one to the restart bit clears the counter; reads zero.
// [R08] Combined restart bit clears clock timer and watchdog; reads zero.
// [R09] Unused bits read zero.
// [R10] Registers decode directly, without any page selection.
// [R11] Software restarts the watchdog cyclically from its main routine.
// [R12] Software restarts in under three seconds; stages unfit for long timing.
// [R13] Restart is one-cycle clear beating a tick; reset request is registered pulse.
`timescale 1ns/1ps
`default_nettype none
`include "wdrt_map.vh"
module wdrt_top #(
    parameter integer TICK_CYCLES = `WDRT_TICK_CYCLES
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg         wdog_reset_req,
    output reg         wdog_half_hz_stage,
    output reg         wdog_quarter_hz_stage
);
    reg  [1:0]  cnt_ff;
    reg  [1:0]  nxt_cnt;
    reg         nxt_rst_req;
    reg  [1:0]  own_ff;
    reg  [1:0]  nxt_own;
    reg  [31:0] nxt_prdata;
    reg         nxt_pslverr;
    reg         wdog_restart;
    reg         timer_restart;
    reg         hit_tmr;
    reg         hit_wdg;
    reg         hit_own;
    wire        acc_phase;
    wire        wr_acc;
    wire        tick_1hz;
    wire        osc_run;

    // Word index decode; byte address is four times the printed offset
    function [7:0] word_idx;
        input [11:0] addr;
        begin
            word_idx = addr[9:2];
        end
    endfunction

    assign acc_phase = psel & penable;
    assign wr_acc    = acc_phase & pwrite & pstrb[0];
    assign osc_run   = ~own_ff[`WDRT_OWN_SLEEP_BIT]; // see [R04]

    always @* begin
        hit_tmr = 1'b0;
        hit_wdg = 1'b0;
        hit_own = 1'b0;
        // Flat decode with no page register in front of it; see [R10]
        if (paddr[1:0] != 2'b00 || paddr[11:10] != 2'b00) begin
            hit_tmr = 1'b0;
        end else if (word_idx(paddr) == `WDRT_IDX_TMR_RESTART) begin
            hit_tmr = 1'b1;
        end else if (word_idx(paddr) == `WDRT_IDX_WDOG_CTRL) begin
            hit_wdg = 1'b1;
        end else if (word_idx(paddr) == `WDRT_IDX_OWN_CTRL) begin
            hit_own = 1'b1;
        end
    end

    always @* begin
        timer_restart = wr_acc & hit_tmr & pwdata[`WDRT_COMBINED_TIMER_RESTART_BIT_BIT];  // see [R08]
        wdog_restart  = (wr_acc & hit_wdg & pwdata[`WDRT_WDOG_RESTART_BIT_BIT])
                      | timer_restart;                               // see [R07]
    end

    wdrt_tick_gen #(
        .DIV_CYCLES (TICK_CYCLES)
    ) u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .restart (timer_restart),
        .run     (osc_run),
        .tick_ff (tick_1hz)
    );

    // Counter next state. Halt does not gate the tick, so HALT time counts.
    always @* begin
        nxt_cnt     = cnt_ff;
        nxt_rst_req = 1'b0;
        if (wdog_restart) begin
            nxt_cnt = `WDRT_CNT_RESET;          // see [R13]
        end else if (tick_1hz) begin
            nxt_cnt = cnt_ff + 2'h1;            // see [R01] [R03]
            // Wrap of the quarter hertz stage: 3 to 4 s after last restart
            nxt_rst_req = (cnt_ff == 2'h3);     // see [R02]
        end
    end

    always @* begin
        nxt_own = own_ff;
        if (wr_acc & hit_own) begin
            nxt_own = pwdata[1:0];
        end
    end

    // Read mux; write-only and unused bits return zero
    always @* begin
        nxt_prdata  = 32'h0000_0000;
        nxt_pslverr = 1'b0;
        if (hit_wdg) begin
            nxt_prdata[`WDRT_WD0_BIT] = cnt_ff[0];   // see [R05]
            nxt_prdata[`WDRT_WD1_BIT] = cnt_ff[1];   // see [R05] [R09]
        end else if (hit_tmr) begin
            nxt_prdata = 32'h0000_0000;              // see [R09]
        end else if (hit_own) begin
            nxt_prdata[1:0] = own_ff;
        end else begin
            nxt_pslverr = 1'b1;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff                <= `WDRT_CNT_RESET;  // see [R06]
            own_ff                <= `WDRT_OWN_RESET;
            prdata                <= 32'h0000_0000;
            pready                <= 1'b0;
            pslverr               <= 1'b0;
            wdog_reset_req        <= 1'b0;
            wdog_half_hz_stage    <= 1'b0;
            wdog_quarter_hz_stage <= 1'b0;
        end else begin
            cnt_ff                <= nxt_cnt;
            own_ff                <= nxt_own;
            // Zero-wait slave: pready rises in the first access cycle
            pready                <= psel & ~penable;
            pslverr               <= (psel & ~penable) ? nxt_pslverr : 1'b0;
            if (psel & ~penable & ~pwrite) begin
                prdata <= nxt_prdata;
            end
            wdog_reset_req        <= nxt_rst_req;      // see [R13]
            wdog_half_hz_stage    <= nxt_cnt[0];
            wdog_quarter_hz_stage <= nxt_cnt[1];
        end
    end
endmodule
`default_nettype wire

// File: design/wdrt_map.vh
// Register offsets, field positions and timing counts for the watchdog reset timer.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef WDRT_MAP_VH
`define WDRT_MAP_VH

// Printed offsets are not multiples of four: they are word indexes
`define WDRT_IDX_TMR_RESTART     8'hE2
`define WDRT_IDX_WDOG_CTRL       8'hE5
`define WDRT_ADDR_W              12

// Field positions
`define WDRT_COMBINED_TIMER_RESTART_BIT_BIT           0
`define WDRT_WD0_BIT             0
`define WDRT_WD1_BIT             1
`define WDRT_WDOG_RESTART_BIT_BIT           3

// Own control and status register (word index)
`define WDRT_IDX_OWN_CTRL        8'hF0
`define WDRT_OWN_HALT_BIT        0
`define WDRT_OWN_SLEEP_BIT       1

// Reset values
`define WDRT_CNT_RESET           2'h0
`define WDRT_OWN_RESET           2'h0

// Timing: 1 Hz tick at a 25 MHz clock
`define WDRT_CLK_HZ              25000000
`define WDRT_TICK_HZ             1
`define WDRT_TICK_CYCLES         (`WDRT_CLK_HZ / `WDRT_TICK_HZ)

`endif

// File: design/wdrt_tick_gen.v
// Clock timer stand-in: divides pclk to a one-cycle 1 Hz tick.
// Assumes one pclk domain; restart clears the divider in step with the watchdog.
`timescale 1ns/1ps
`default_nettype none
module wdrt_tick_gen #(
    parameter integer DIV_CYCLES = 25000000
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        restart,
    input  wire        run,
    output reg         tick_ff
);
    reg  [31:0] div_ff;
    wire        last;

    assign last = (div_ff == DIV_CYCLES - 1);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_ff  <= 32'h0000_0000;
            tick_ff <= 1'b0;
        end else if (restart) begin
            div_ff  <= 32'h0000_0000;
            tick_ff <= 1'b0;
        end else if (run) begin
            div_ff  <= last ? 32'h0000_0000 : div_ff + 32'h0000_0001;
            tick_ff <= last;
        end else begin
            // Oscillation stopped: the divider holds, no tick
            tick_ff <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: dv/wdrt_top_properties.sv
// Assertions on the wdrt_top ports: APB answers and watchdog count.
// Assumes one pclk domain with active-low asynchronous presetn.
`timescale 1ns/1ps
`default_nettype none
module wdrt_props (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        wdog_reset_req,
    input wire logic        wdog_half_hz_stage,
    input wire logic        wdog_quarter_hz_stage
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire [1:0] cnt = {wdog_quarter_hz_stage, wdog_half_hz_stage};
    wire       wr  = psel && penable && pready && pwrite;
    a_ready_setup: assert property (psel && !penable |=> pready)
        else $error("ready");
    a_ready_once: assert property (pready |=> !pready) else $error("ready width");
    a_unused_zero: assert property (pready && !pwrite && paddr == 12'h394 |-> !prdata[31:2])
        else $error("unused");
    a_step_one: assert property (cnt != $past(cnt) |-> cnt == $past(cnt) + 2'h1 || !cnt)
        else $error("step");
    a_req_pulse: assert property (wdog_reset_req |=> !wdog_reset_req)
        else $error("req");
    a_req_zero: assert property (wdog_reset_req |-> !cnt) else $error("req cnt");
    a_wd_clear: assert property (wr && paddr == 12'h394 && pwdata[3] |=> !cnt)
        else $error("restart");
    a_tmr_clear: assert property (wr && paddr == 12'h388 && pwdata[0] |=> !cnt)
        else $error("restart all");
endmodule
bind wdrt_top wdrt_props i_wdrt_props (.*);
`default_nettype wire

// File: dv/wdrt_cpu_model.sv
// CPU side: answers a watchdog request with a one-edge reset pulse.
// Assumes the request is a single-cycle pulse on pclk.
`timescale 1ns/1ps
`default_nettype none
module wdrt_cpu_model (
    input  wire logic pclk,
    input  wire logic wdog_reset_req,
    output var logic  cpu_rst_n = 1'b1,
    output var int    n_resets = 0
);
    always @(posedge pclk) begin
        cpu_rst_n <= !wdog_reset_req;
        if (wdog_reset_req) n_resets <= n_resets + 1;
    end
endmodule
`default_nettype wire

// File: dv/wdrt_top_bench.sv
// Bench: APB sequences on the watchdog, CPU reset modelled.
// Assumes an 8-cycle tick, so a timeout takes some 32 cycles.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin error_cnt++; \
    $display("FAIL %s exp %h got %h", n, e, a); end end
module wdrt_top_bench;
    logic        pclk, presetn, rst_n, cpu_rst_n, psel, penable, pwrite, pready, pslverr, er;
    logic        wdog_reset_req, wdog_half_hz_stage, wdog_quarter_hz_stage;
    logic [3:0]  pstrb = 4'hf;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int          error_cnt, n_tests, n_resets, k;
    wire  [1:0]  cnt = {wdog_quarter_hz_stage, wdog_half_hz_stage};
    assign presetn = rst_n & cpu_rst_n;
    wdrt_top #(.TICK_CYCLES(8)) i_wdrt_top (.*);
    wdrt_cpu_model i_wdrt_cpu_model (.*);
    initial begin
        pclk = 0;
        forever #20 pclk = ~pclk;
    end
    task wrap_up;
        $display("n_tests %0d error_cnt %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Request held until the rising edge that samples pready high; answer taken there
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 9);
        `CHK("pready", 1'b1, pready)
        if (k >= 9) wrap_up();
        {rd, er} = {prdata, pslverr};
        {psel, penable} <= 2'b0;
    endtask
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata, error_cnt, n_tests} = 0;
        repeat (8) @(posedge pclk);
        rst_n <= 1;
        xfer(0, 12'h394, 0);
        `CHK("ctrl", 32'h0, rd)
        xfer(0, 12'h004, 0);
        `CHK("err", 1'b1, er)
        xfer(0, 12'h388, 0);
        `CHK("restart rd", 32'h0, rd)
        xfer(1, 12'h3c0, 1);
        xfer(1, 12'h388, 1);
        xfer(1, 12'h394, 3);
        xfer(0, 12'h394, 0);
        `CHK("ctrl", 32'h0, rd)
        repeat (21) @(negedge pclk);
        `CHK("cnt", 2'h3, cnt)
        for (k = 0; k < 12 && n_resets == 0; k++) @(negedge pclk);
        `CHK("resets", 1, n_resets)
        `CHK("cnt", 2'h0, cnt)
        // Kicks every 17 cycles, inside the three-tick margin
        repeat (6) begin
            repeat (15) @(negedge pclk);
            xfer(1, 12'h394, 8);
        end
        `CHK("resets", 1, n_resets)
        xfer(1, 12'h388, 1);
        repeat (10) @(negedge pclk);
        xfer(1, 12'h3c0, 2);
        repeat (40) @(negedge pclk);
        `CHK("cnt", 2'h1, cnt)
        xfer(1, 12'h3c0, 0);
        repeat (7) @(negedge pclk);
        `CHK("cnt", 2'h2, cnt)
        wrap_up();
    end
endmodule
`default_nettype wire
